// ---- rtl/slpc_consts.svh ----
// Offsets, field positions, reset values and timing for the strap,
// indicator and power control block.
// Assumes a 40 MHz reference clock and a 5-bit management address.
`ifndef SLPC_CONSTS_SVH
`define SLPC_CONSTS_SVH

`define SLPC_CLK_HZ          40000000
`define SLPC_QUIET_S         32
`define SLPC_QUIET_CYCLES    (`SLPC_QUIET_S * `SLPC_CLK_HZ)
`define SLPC_SETTLE_LAST     3'h4

`define SLPC_ADR_BCTL        5'h00
`define SLPC_ADR_BSTAT       5'h01
`define SLPC_ADR_ID_HI       5'h02
`define SLPC_ADR_ID_LO       5'h03
`define SLPC_ADR_ANADV       5'h04
`define SLPC_ADR_ANLPA       5'h05
`define SLPC_ADR_ANEXP       5'h06
`define SLPC_ADR_NPTX        5'h07
`define SLPC_ADR_NPLP        5'h08
`define SLPC_ADR_RSV_LO      5'h09
`define SLPC_ADR_RSV_HI      5'h0f
`define SLPC_ADR_IND         5'h14
`define SLPC_ADR_PDC         5'h18

`define SLPC_RST_BCTL        16'h3100
`define SLPC_RST_BSTAT       16'h7809
`define SLPC_RST_ANADV       16'h01e1
`define SLPC_RST_ZERO        16'h0000
`define SLPC_RST_IND         16'h0010
`define SLPC_RST_PDC         16'h01f0

`define SLPC_BCTL_RESET      15
`define SLPC_BCTL_SPEED      13
`define SLPC_BCTL_ISOLATE    10
`define SLPC_BCTL_DUPLEX     8
`define SLPC_BSTAT_LINK      2
`define SLPC_PDC_SEL_HI      8
`define SLPC_PDC_SEL_LO      4
`define SLPC_IND_A_HI        2
`define SLPC_IND_A_LO        0
`define SLPC_IND_B_HI        6
`define SLPC_IND_B_LO        4
`define SLPC_SEL_W           5

`endif

// ---- rtl/slpc_pkg.sv ----
// Types shared by the strap, indicator and power control block.
// Enum encodings are literals here; slpc_consts.svh supplies none of them.
package slpc_pkg;
    typedef enum logic [2:0] {
        SLPC_IND_LINK = 3'b000,
        SLPC_IND_ACT  = 3'b001,
        SLPC_IND_TX   = 3'b010,
        SLPC_IND_RX   = 3'b011,
        SLPC_IND_COL  = 3'b100,
        SLPC_IND_MODE = 3'b101,
        SLPC_IND_DPLX = 3'b110,
        SLPC_IND_OFF  = 3'b111
    } slpc_ind_sel_t;

    typedef enum logic [1:0] {
        SLPC_ST_STRAP = 2'b00,
        SLPC_ST_AWAKE = 2'b01,
        SLPC_ST_DEEP  = 2'b10
    } slpc_state_t;
endpackage

// ---- rtl/slpc_strap_led_power_control.sv ----
// Strap capture, indicator drive, deep sleep control and management
// register decode of an Ethernet PHY.
// Assumes a management frame engine outside presents decoded accesses
// (address, write strobe, data) on REF_CLK, and that link status comes
// from the receive path; pin levels arrive asynchronously.
//
// Functional notes
// - Sleep after 32 s quiet with no transmit
// - Sleep gates only sections chosen in power_down_config
// - indicator_config chooses what the indicators show
// - Indicators show link, activity, tx, rx, col, speed, duplex
// - Strap pins sampled at reset exit, then drive
// - Software reset keeps straps, pins stay outputs
// - Asserted indicator level is inverse of strap
// - PHY address taken from captured strap levels
// - Address zero floats all MII outputs
// - Management map: basic, extended, reserved, vendor
`timescale 1ns/10ps
`include "slpc_consts.svh"

module slpc_strap_led_power_control #(
    parameter int unsigned QUIET_CYCLES = `SLPC_QUIET_CYCLES
) (
    input  wire logic                         REF_CLK,
    input  wire logic                         RESET,
    input  wire logic                         TX_ENABLE,
    input  wire logic                         LINE_SIGNAL,
    input  wire logic                         LINK_UP,
    input  wire logic                         RX_ACTIVE,
    input  wire logic                         COLLISION,
    input  wire logic                         STRAP_INDICATOR_PIN_A_IN,
    output logic                              STRAP_INDICATOR_PIN_A_OUT,
    output logic                              STRAP_INDICATOR_PIN_A_OE,
    input  wire logic                         STRAP_INDICATOR_PIN_B_IN,
    output logic                              STRAP_INDICATOR_PIN_B_OUT,
    output logic                              STRAP_INDICATOR_PIN_B_OE,
    input  wire logic [4:0]                   MGMT_ADDR,
    input  wire logic                         MGMT_WRITE,
    input  wire logic [15:0]                  MGMT_WDATA,
    output logic      [15:0]                  MGMT_RDATA,
    output logic      [1:0]                   PHY_ADDRESS,
    output logic                              MII_OUTPUT_ENABLE,
    output logic                              DEEP_SLEEP_MODE,
    output logic      [`SLPC_SEL_W-1:0]       SECTION_SHUTDOWN,
    output logic                              SOFT_RESET
);
    import slpc_pkg::*;

    // Refuse a quiet time the counter compare cannot serve
    if (QUIET_CYCLES < 2) begin : g_bad_quiet
        $error("QUIET_CYCLES must be at least 2");
    end

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    // Three stages; a level counts when stages two and three agree.
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic [4:0] sync3_reg;
    logic [4:0] clean_reg;
    logic [4:0] raw_in;

    assign raw_in = {COLLISION, RX_ACTIVE, LINE_SIGNAL,
                     STRAP_INDICATOR_PIN_B_IN, STRAP_INDICATOR_PIN_A_IN};

    always_ff @(posedge REF_CLK) begin
        sync1_reg <= raw_in;
        sync2_reg <= sync1_reg;
        sync3_reg <= sync2_reg;
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            clean_reg <= 5'h00;
        end else begin
            for (int i = 0; i < 5; i++) begin
                if (sync2_reg[i] == sync3_reg[i])
                    clean_reg[i] <= sync3_reg[i];
            end
        end
    end

    logic pin_a_lvl;
    logic pin_b_lvl;
    logic line_lvl;
    logic rx_lvl;
    logic col_lvl;
    assign {col_lvl, rx_lvl, line_lvl, pin_b_lvl, pin_a_lvl} = clean_reg;

    // ************************************************************
    // Strap capture
    // ************************************************************
    // Pins are inputs while RESET is high, then one settle pass lets
    // the filtered level reflect the pin before it is latched.
    slpc_state_t state_reg;
    logic        strap_done_reg;
    logic [2:0]  settle_reg;
    logic [1:0]  strap_reg;

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            strap_done_reg <= 1'b0;
            settle_reg     <= 3'h0;
        end else if (!strap_done_reg) begin
            settle_reg <= settle_reg + 3'h1;
            if (settle_reg == `SLPC_SETTLE_LAST)
                strap_done_reg <= 1'b1;
        end
    end

    // Held through software reset, which never touches this process.
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            strap_reg <= 2'h0;
        end else if (!strap_done_reg
                     && settle_reg == `SLPC_SETTLE_LAST) begin
            strap_reg <= {pin_b_lvl, pin_a_lvl};
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            PHY_ADDRESS       <= 2'h0;
            MII_OUTPUT_ENABLE <= 1'b0;
        end else begin
            PHY_ADDRESS       <= strap_reg;
            MII_OUTPUT_ENABLE <= strap_done_reg
                                 && (strap_reg != 2'h0);
        end
    end

    // ************************************************************
    // Management registers
    // ************************************************************
    logic [15:0] bctl_reg;
    logic [15:0] anadv_reg;
    logic [15:0] nptx_reg;
    logic [15:0] ind_reg;
    logic [15:0] pdc_reg;
    logic        soft_rst;

    assign soft_rst = bctl_reg[`SLPC_BCTL_RESET];

    // Software reset returns registers to defaults but not the strap.
    always_ff @(posedge REF_CLK) begin
        if (RESET || soft_rst) begin
            bctl_reg  <= `SLPC_RST_BCTL;
            anadv_reg <= `SLPC_RST_ANADV;
            nptx_reg  <= `SLPC_RST_ZERO;
            ind_reg   <= `SLPC_RST_IND;
            pdc_reg   <= `SLPC_RST_PDC;
        end else if (MGMT_WRITE) begin
            unique case (MGMT_ADDR)
                `SLPC_ADR_BCTL:  bctl_reg  <= MGMT_WDATA;
                `SLPC_ADR_ANADV: anadv_reg <= MGMT_WDATA;
                `SLPC_ADR_NPTX:  nptx_reg  <= MGMT_WDATA;
                `SLPC_ADR_IND:   ind_reg   <= MGMT_WDATA;
                `SLPC_ADR_PDC:   pdc_reg   <= MGMT_WDATA;
                default: ;
            endcase
        end
    end

    logic [15:0] bstat;
    always_comb begin
        bstat = `SLPC_RST_BSTAT;
        bstat[`SLPC_BSTAT_LINK] = LINK_UP;
    end

    // Reserved and unbuilt vendor addresses read as zero.
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            MGMT_RDATA <= `SLPC_RST_ZERO;
        end else begin
            unique case (MGMT_ADDR)
                `SLPC_ADR_BCTL:  MGMT_RDATA <= bctl_reg;
                `SLPC_ADR_BSTAT: MGMT_RDATA <= bstat;
                `SLPC_ADR_ANADV: MGMT_RDATA <= anadv_reg;
                `SLPC_ADR_NPTX:  MGMT_RDATA <= nptx_reg;
                `SLPC_ADR_IND:   MGMT_RDATA <= ind_reg;
                `SLPC_ADR_PDC:   MGMT_RDATA <= pdc_reg;
                default:         MGMT_RDATA <= `SLPC_RST_ZERO;
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET)
            SOFT_RESET <= 1'b0;
        else
            SOFT_RESET <= soft_rst;
    end

    // ************************************************************
    // Deep sleep control
    // ************************************************************
    // The quiet counter restarts on line signal or transmit; busy clears the sleep outputs on the next clock.
    logic [35:0] quiet_reg;
    logic        busy;

    assign busy = line_lvl || TX_ENABLE;

    always_ff @(posedge REF_CLK) begin
        if (RESET || busy) begin
            quiet_reg <= 36'h0;
        end else if (quiet_reg != 36'(QUIET_CYCLES)) begin
            quiet_reg <= quiet_reg + 36'h1;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            state_reg <= SLPC_ST_STRAP;
        end else begin
            unique case (state_reg)
                SLPC_ST_STRAP:
                    if (strap_done_reg)
                        state_reg <= SLPC_ST_AWAKE;
                SLPC_ST_AWAKE:
                    // A quiet spell begun during strap capture still counts
                    if (!busy && quiet_reg >= 36'(QUIET_CYCLES - 1))
                        state_reg <= SLPC_ST_DEEP;
                SLPC_ST_DEEP:
                    if (busy)
                        state_reg <= SLPC_ST_AWAKE;
                default: state_reg <= SLPC_ST_STRAP;
            endcase
        end
    end

    logic deep;
    assign deep = (state_reg == SLPC_ST_DEEP);

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            DEEP_SLEEP_MODE  <= 1'b0;
            SECTION_SHUTDOWN <= '0;
        end else begin
            DEEP_SLEEP_MODE  <= deep && !busy;
            SECTION_SHUTDOWN <= (deep && !busy)
                ? pdc_reg[`SLPC_PDC_SEL_HI:`SLPC_PDC_SEL_LO]
                : '0;
        end
    end

    // ************************************************************
    // Indicator drive
    // ************************************************************
    function automatic logic ind_event(input logic [2:0] sel);
        unique case (slpc_ind_sel_t'(sel))
            SLPC_IND_LINK: ind_event = LINK_UP;
            SLPC_IND_ACT:  ind_event = TX_ENABLE || rx_lvl;
            SLPC_IND_TX:   ind_event = TX_ENABLE;
            SLPC_IND_RX:   ind_event = rx_lvl;
            SLPC_IND_COL:  ind_event = col_lvl;
            SLPC_IND_MODE: ind_event = bctl_reg[`SLPC_BCTL_SPEED];
            SLPC_IND_DPLX: ind_event = bctl_reg[`SLPC_BCTL_DUPLEX];
            SLPC_IND_OFF:  ind_event = 1'b0;
        endcase
    endfunction

    // Pins stay outputs through software reset once the strap is taken.
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            STRAP_INDICATOR_PIN_A_OE  <= 1'b0;
            STRAP_INDICATOR_PIN_B_OE  <= 1'b0;
            STRAP_INDICATOR_PIN_A_OUT <= 1'b0;
            STRAP_INDICATOR_PIN_B_OUT <= 1'b0;
        end else begin
            STRAP_INDICATOR_PIN_A_OE  <= strap_done_reg;
            STRAP_INDICATOR_PIN_B_OE  <= strap_done_reg;
            STRAP_INDICATOR_PIN_A_OUT <= strap_reg[0] ^ ind_event(
                ind_reg[`SLPC_IND_A_HI:`SLPC_IND_A_LO]);
            STRAP_INDICATOR_PIN_B_OUT <= strap_reg[1] ^ ind_event(
                ind_reg[`SLPC_IND_B_HI:`SLPC_IND_B_LO]);
        end
    end

endmodule // slpc_strap_led_power_control

// ---- tb/slpc_checker_sva.sv ----
// Concurrent checks on the ports of the strap and power control block.
// Assumes it is bound to the top module from tb_top.
`timescale 1ns/10ps
module slpc_checker_sva (
    input wire logic        REF_CLK,
    input wire logic        RESET,
    input wire logic        TX_ENABLE,
    input wire logic        LINE_SIGNAL,
    input wire logic        STRAP_INDICATOR_PIN_A_OE,
    input wire logic        STRAP_INDICATOR_PIN_B_OE,
    input wire logic [4:0]  MGMT_ADDR,
    input wire logic [15:0] MGMT_RDATA,
    input wire logic [1:0]  PHY_ADDRESS,
    input wire logic        MII_OUTPUT_ENABLE,
    input wire logic        DEEP_SLEEP_MODE,
    input wire logic [4:0]  SECTION_SHUTDOWN,
    input wire logic        SOFT_RESET
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);
    chk_awake_no_shut: assert property (
        !DEEP_SLEEP_MODE |-> SECTION_SHUTDOWN == 5'h00)
        else $error("sections shut while awake");
    chk_sleep_quiet: assert property (
        $rose(DEEP_SLEEP_MODE) |-> !$past(TX_ENABLE))
        else $error("sleep entered during transmit");
    chk_wake_tx: assert property (
        DEEP_SLEEP_MODE && TX_ENABLE |=> !DEEP_SLEEP_MODE)
        else $error("no wake on transmit");
    chk_wake_line: assert property (
        LINE_SIGNAL [*6] |-> !DEEP_SLEEP_MODE)
        else $error("asleep with line signal");
    chk_mii_addr: assert property (
        STRAP_INDICATOR_PIN_A_OE ##1 STRAP_INDICATOR_PIN_A_OE
        |-> MII_OUTPUT_ENABLE == (PHY_ADDRESS != 2'b00))
        else $error("mii enable disagrees with address");
    chk_addr_kept: assert property (
        STRAP_INDICATOR_PIN_A_OE && $past(STRAP_INDICATOR_PIN_A_OE)
        |-> $stable(PHY_ADDRESS))
        else $error("address changed after capture");
    chk_pins_drive: assert property (
        STRAP_INDICATOR_PIN_A_OE
        |=> STRAP_INDICATOR_PIN_A_OE && STRAP_INDICATOR_PIN_B_OE)
        else $error("pins stopped driving");
    chk_soft_pins: assert property (
        SOFT_RESET |-> STRAP_INDICATOR_PIN_A_OE && STRAP_INDICATOR_PIN_B_OE)
        else $error("pins released in soft reset");
    chk_resv_zero: assert property (
        MGMT_ADDR inside {[5'h09:5'h0f]} |=> MGMT_RDATA == 16'h0000)
        else $error("reserved address not zero");
    cov_sleep: cover property ($rose(DEEP_SLEEP_MODE));
    cov_soft: cover property (SOFT_RESET);
    cov_mii_off: cover property (STRAP_INDICATOR_PIN_A_OE && !MII_OUTPUT_ENABLE);
endmodule // slpc_checker_sva

// ---- tb/slpc_board_pins.sv ----
// Board side of the two strap pins: strap resistor plus indicator.
// Assumes output enable is high while the block drives a pin.
`timescale 1ns/10ps
module slpc_board_pins (
    input  wire logic pull_a,
    input  wire logic en_a,
    input  wire logic val_a,
    input  wire logic pull_b,
    input  wire logic en_b,
    input  wire logic val_b,
    output logic      pin_a,
    output logic      pin_b
);
    // A released pin never floats: the resistor sets its level
    assign pin_a = en_a ? val_a : pull_a;
    assign pin_b = en_b ? val_b : pull_b;
endmodule // slpc_board_pins

// ---- tb/tb_top.sv ----
// Self-checking bench for the strap, indicator and power control block.
// Assumes design, board model and checker are compiled before it.
`timescale 1ns/10ps
`include "slpc_consts.svh"
module tb_top;
    localparam int unsigned QC = 20;
    logic clk = 1'b0, rst = 1'b1, txe = 1'b0, line = 1'b1, lnk = 1'b0;
    logic rxa = 1'b0, col = 1'b0, wen = 1'b0, pull_a = 1'b1, pull_b = 1'b0;
    logic        pa, pb, oa, ob, ea, eb, mii, deep, srst;
    logic [4:0]  adr = 5'h00, shut;
    logic [15:0] wd = 16'h0000, rd;
    logic [1:0]  paddr;
    int          num_errors = 0, cmp_count = 0, cyc = 0;
    always #12.5 clk = ~clk;
    slpc_strap_led_power_control #(.QUIET_CYCLES(QC))
        slpc_strap_led_power_control_i (.REF_CLK(clk), .RESET(rst),
        .TX_ENABLE(txe), .LINE_SIGNAL(line), .LINK_UP(lnk),
        .RX_ACTIVE(rxa), .COLLISION(col), .STRAP_INDICATOR_PIN_A_IN(pa),
        .STRAP_INDICATOR_PIN_A_OUT(oa), .STRAP_INDICATOR_PIN_A_OE(ea),
        .STRAP_INDICATOR_PIN_B_IN(pb), .STRAP_INDICATOR_PIN_B_OUT(ob),
        .STRAP_INDICATOR_PIN_B_OE(eb), .MGMT_ADDR(adr), .MGMT_WRITE(wen),
        .MGMT_WDATA(wd), .MGMT_RDATA(rd), .PHY_ADDRESS(paddr),
        .MII_OUTPUT_ENABLE(mii), .DEEP_SLEEP_MODE(deep),
        .SECTION_SHUTDOWN(shut), .SOFT_RESET(srst));
    slpc_board_pins slpc_board_pins_i (.pull_a(pull_a), .en_a(ea),
        .val_a(oa), .pull_b(pull_b), .en_b(eb), .val_b(ob), .pin_a(pa),
        .pin_b(pb));
    // ****************************************
    // Helpers
    // ****************************************
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            $display("[ERR] %0t: timeout", $time);
            num_errors++;
            final_report();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge clk);
        adr = a; wd = d; wen = 1'b1;
        @(negedge clk);
        wen = 1'b0;
    endtask
    task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
        @(negedge clk);
        adr = a;
        @(negedge clk);
        chk(rd, exp);
    endtask
    task automatic hw_reset();
        @(negedge clk);
        rst = 1'b1;
        wait_n(3);
        rst = 1'b0;
        wait_n(12);
    endtask
    task automatic ev(input int c, input logic v);
        case (c)
            0: lnk = v;
            1, 3: rxa = v;
            2: txe = v;
            4: col = v;
            5, 6: wr(`SLPC_ADR_BCTL, v ? 16'h3100 : 16'h1000);
            default: ;
        endcase
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_strap();
        chk(16'(paddr), 16'({pull_b, pull_a}));
        chk(16'(ea & eb), 16'h0001);
        chk(16'(mii), 16'(pull_a | pull_b));
        $display("strap test done");
    endtask
    task automatic t_regs();
        rdc(`SLPC_ADR_BCTL, `SLPC_RST_BCTL);
        rdc(`SLPC_ADR_IND, `SLPC_RST_IND);
        rdc(`SLPC_ADR_PDC, `SLPC_RST_PDC);
        wr(`SLPC_ADR_BSTAT, 16'hffff);
        rdc(`SLPC_ADR_BSTAT, `SLPC_RST_BSTAT);
        lnk = 1'b1;
        rdc(`SLPC_ADR_BSTAT, `SLPC_RST_BSTAT | 16'h0004);
        lnk = 1'b0;
        rdc(`SLPC_ADR_ID_HI, 16'h0000);
        rdc(`SLPC_ADR_ANADV, `SLPC_RST_ANADV);
        wr(`SLPC_ADR_RSV_LO, 16'hffff);
        rdc(`SLPC_ADR_RSV_LO, 16'h0000);
        rdc(`SLPC_ADR_RSV_HI, 16'h0000);
        wr(`SLPC_ADR_PDC, 16'h0050);
        rdc(`SLPC_ADR_PDC, 16'h0050);
        $display("register test done");
    endtask
    task automatic t_ind();
        for (int c = 0; c < 8; c++) begin
            wr(`SLPC_ADR_IND, 16'h0070 | 16'(c));
            ev(c, 1'b1);
            wait_n(8);
            chk(16'(oa), 16'(c == 7 ? pull_a : !pull_a));
            chk(16'(ob), 16'(pull_b));
            ev(c, 1'b0);
            wait_n(8);
            chk(16'(oa), 16'(pull_a));
        end
        wr(`SLPC_ADR_IND, `SLPC_RST_IND);
        ev(1, 1'b1);
        wait_n(8);
        chk(16'(ob), 16'(!pull_b));
        chk(16'(oa), 16'(pull_a));
        ev(1, 1'b0);
        $display("indicator test done");
    endtask
    task automatic t_sleep();
        line = 1'b0;
        wait_n(QC - 4);
        chk(16'(deep), 16'h0000);
        wait_n(10);
        chk(16'(deep), 16'h0001);
        chk(16'(shut), 16'h0005);
        txe = 1'b1;
        wait_n(2);
        chk(16'(deep), 16'h0000);
        chk(16'(shut), 16'h0000);
        txe = 1'b0;
        wait_n(QC + 10);
        chk(16'(deep), 16'h0001);
        line = 1'b1;
        wait_n(6);
        chk(16'(deep), 16'h0000);
        $display("sleep test done");
    endtask
    task automatic t_soft();
        wr(`SLPC_ADR_IND, 16'h0077);
        wr(`SLPC_ADR_BCTL, 16'h8000);
        wait_n(1);
        chk(16'(srst), 16'h0001);
        wait_n(1);
        chk(16'(srst), 16'h0000);
        rdc(`SLPC_ADR_IND, `SLPC_RST_IND);
        rdc(`SLPC_ADR_BCTL, `SLPC_RST_BCTL);
        chk(16'(paddr), 16'({pull_b, pull_a}));
        chk(16'(ea & eb), 16'h0001);
        $display("soft reset test done");
    endtask
    initial begin
        hw_reset();
        t_strap();
        t_regs();
        t_ind();
        t_sleep();
        t_soft();
        pull_a = 1'b0;
        hw_reset();
        t_strap();
        final_report();
    end
endmodule // tb_top
bind slpc_strap_led_power_control slpc_checker_sva slpc_checker_sva_i (
    .REF_CLK, .RESET, .TX_ENABLE, .LINE_SIGNAL, .STRAP_INDICATOR_PIN_A_OE,
    .STRAP_INDICATOR_PIN_B_OE, .MGMT_ADDR, .MGMT_RDATA, .PHY_ADDRESS,
    .MII_OUTPUT_ENABLE, .DEEP_SLEEP_MODE, .SECTION_SHUTDOWN, .SOFT_RESET);
